// ===== core/nvme_host_core.sv
// Four-port command engines sharing one drive link, with link-clock packet sender.
`include "nvme_host_map.svh"
`timescale 1ns/1ns
`default_nettype none

// Three-flop synchroniser; a change counts once stages two and three agree.
module sync3 (
   input wire logic clk,
   input wire logic rst,
   input wire logic d,
   output logic q_q,
   output logic chg_q
);
   logic s1_q, s2_q, s3_q;
   // Chain plus settled level and change pulse.
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         q_q <= 1'b0;
         chg_q <= 1'b0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         chg_q <= (s2_q == s3_q) && (s3_q != q_q);
         if (s2_q == s3_q) begin
            q_q <= s3_q;
         end
      end
   end
endmodule

module multi_user_nvme_host_cmd #(
   parameter bit BUF_SMALL = 1'b0
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic link_clk,
   input wire logic link_up,
   input wire logic [3:0] cmd_req,
   input wire logic [2:0] main_port_command_code,
   input wire logic [2:0][2:0] secondary_port_command_code,
   input wire logic [3:0][47:0] start_addr,
   input wire logic [3:0][31:0] xfer_len,
   input wire logic [511:0] custom_submission_dwords,
   input wire logic [3:0] wr_valid,
   input wire logic [3:0] rd_ready,
   output logic [3:0] wr_ready_q,
   output logic [3:0] rd_valid_q,
   output logic [3:0] busy_q,
   output logic [15:0] admin_completion_status_q,
   output logic [3:0][15:0] io_completion_status_q,
   output logic [47:0] disk_capacity_blocks_q,
   output logic block_unit_select_q,
   output logic custom_ram_wr_q,
   output logic [4:0] custom_ram_word_index_q,
   output logic ident_ram_wr_q,
   output logic [7:0] ident_ram_word_index_q,
   output logic error_q,
   output logic [3:0] error_code_q,
   output logic [255:0] tx_data_q,
   output logic tx_valid_q,
   output logic tx_last_q,
   input wire logic tx_ready,
   input wire logic rx_valid,
   input wire logic [1:0] rx_port,
   input wire logic [15:0] rx_status,
   input wire logic [63:0] rx_param
);
   import nvme_host_pkg::*;

   // Buffer depth in 256-bit beats, fixed at build time.
   localparam logic [16:0] CAP = BUF_SMALL ? `CAP_BEATS_SMALL : `CAP_BEATS_BIG;

   eng_state_t st_q [4]; // Engine state per port.
   logic [2:0] opc_q [4]; // Command being run.
   logic [31:0] rem_q [4]; // Sectors still to move.
   logic [47:0] addr_q [4]; // Next sector address.
   logic [31:0] chunk_q [4]; // Sectors in the current chunk.
   logic [16:0] fill_q [4]; // Buffer beats held.
   logic [16:0] fill_d [4];
   logic [3:0] err_q [4]; // Sticky error bits per port.
   logic [2:0] ucode [4]; // Code offered by each port.
   logic [31:0] nchunk [4]; // Size of the next chunk.
   logic [3:0] sendv, gnt;
   logic [1:0] gsel, chan_port_q;
   logic chan_busy_q, req_tog_q, kill_q, init_done_q;
   logic [255:0] beat0_q, beat1_q;
   logic [7:0] xfer_cnt_q;
   logic link_ok; // Settled link-up level.
   // Link-domain signals, plus ack_chg and comp_chg on ref_clk.
   logic lr1_q, lr2_q, lrst;
   logic req_chg, ack_tog_l_q, comp_tog_l_q;
   logic [1:0] comp_port_l_q;
   logic [15:0] comp_status_l_q;
   logic [63:0] comp_param_l_q;
   logic ack_chg, comp_chg;

   // ---------------------------------------------------------------
   // Clock crossing
   // ---------------------------------------------------------------
   // Link reset follows the user reset through a three-flop chain.
   always_ff @(posedge link_clk) begin
      lr1_q <= srst;
      lr2_q <= lr1_q;
      lrst <= lr2_q;
   end

   sync3 u_lnk (.clk(ref_clk), .rst(srst), .d(link_up), .q_q(link_ok), .chg_q());
   sync3 u_req (.clk(link_clk), .rst(lrst), .d(req_tog_q), .q_q(), .chg_q(req_chg));
   sync3 u_ack (.clk(ref_clk), .rst(srst), .d(ack_tog_l_q), .q_q(), .chg_q(ack_chg));
   sync3 u_cmp (.clk(ref_clk), .rst(srst), .d(comp_tog_l_q), .q_q(), .chg_q(comp_chg));

   // ---------------------------------------------------------------
   // Link side: packet sender and completion catcher
   // ---------------------------------------------------------------
   // Two-beat command packet; valid never drops mid-packet.
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         tx_valid_q <= 1'b0;
         tx_last_q <= 1'b0;
         tx_data_q <= 256'h0;
         ack_tog_l_q <= 1'b0;
      end else if (req_chg && !tx_valid_q) begin
         tx_valid_q <= 1'b1;
         tx_data_q <= beat0_q;
      end else if (tx_valid_q && tx_ready) begin
         if (!tx_last_q) begin
            tx_data_q <= beat1_q;
            tx_last_q <= 1'b1;
         end else begin
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
            ack_tog_l_q <= ~ack_tog_l_q;
         end
      end
   end

   // Completions are held and announced by toggle.
   always_ff @(posedge link_clk) begin
      if (lrst) begin
         comp_tog_l_q <= 1'b0;
         comp_port_l_q <= 2'h0;
         comp_status_l_q <= 16'h0;
         comp_param_l_q <= 64'h0;
      end else if (rx_valid) begin
         comp_tog_l_q <= ~comp_tog_l_q;
         comp_port_l_q <= rx_port;
         comp_status_l_q <= rx_status;
         comp_param_l_q <= rx_param;
      end
   end

   // ---------------------------------------------------------------
   // Shared command channel
   // ---------------------------------------------------------------
   // Lowest waiting port wins the channel.
   always_comb begin
      gnt = 4'h0;
      gsel = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         sendv[i] = (st_q[i] == S_SEND);
         if (sendv[i] && !chan_busy_q) begin
            gnt = 4'h0;
            gnt[i] = 1'b1;
            gsel = 2'(i);
         end
      end
   end

   // Beats stay stable until the link acknowledges them.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         chan_busy_q <= 1'b0;
         req_tog_q <= 1'b0;
         chan_port_q <= 2'h0;
         beat0_q <= 256'h0;
         beat1_q <= 256'h0;
      end else if (ack_chg) begin
         chan_busy_q <= 1'b0;
      end else if (|gnt) begin
         chan_busy_q <= 1'b1;
         req_tog_q <= ~req_tog_q;
         chan_port_q <= gsel;
         if (opc_q[gsel] == `CMD_LOG || opc_q[gsel] == `CMD_FLUSH) begin
            {beat1_q, beat0_q} <= custom_submission_dwords;
         end else begin
            beat0_q <= {166'h0, gsel, 5'h0, opc_q[gsel], addr_q[gsel], chunk_q[gsel]};
            beat1_q <= 256'h0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Command engines
   // ---------------------------------------------------------------
   // Offered code and next chunk size per port.
   always_comb begin
      ucode[0] = main_port_command_code;
      // Port j+1 takes its code from slot j, so no select ever falls out of range.
      for (int i = 1; i < 4; i++) begin
         ucode[i] = secondary_port_command_code[i - 1];
      end
      for (int i = 0; i < 4; i++) begin
         nchunk[i] = (rem_q[i] >= `CHUNK_UNITS) ? `CHUNK_UNITS : rem_q[i];
      end
   end

   // One engine per port; port 0 also initialises and owns admin work.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         kill_q <= 1'b0;
         init_done_q <= 1'b0;
         busy_q <= 4'h0;
         admin_completion_status_q <= 16'h0;
         disk_capacity_blocks_q <= 48'h0;
         block_unit_select_q <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            st_q[i] <= S_INIT;
            opc_q[i] <= `CMD_IDENT;
            rem_q[i] <= 32'h0;
            addr_q[i] <= 48'h0;
            chunk_q[i] <= 32'h0;
            err_q[i] <= 4'h0;
            io_completion_status_q[i] <= 16'h0;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (kill_q) begin
               st_q[i] <= S_DEAD;
               busy_q[i] <= 1'b0;
            end else begin
               unique case (st_q[i])
                  S_INIT: begin
                     if (i == 0 && link_ok) begin
                        opc_q[i] <= `CMD_SETUP;
                        st_q[i] <= S_SEND;
                     end else if (i != 0 && init_done_q) begin
                        st_q[i] <= S_IDLE;
                     end
                  end
                  S_IDLE: begin
                     if (cmd_req[i]) begin
                        if (ucode[i] == `CMD_WRITE || ucode[i] == `CMD_READ) begin
                           opc_q[i] <= ucode[i];
                           rem_q[i] <= xfer_len[i];
                           addr_q[i] <= start_addr[i];
                           st_q[i] <= S_WAIT;
                           busy_q[i] <= 1'b1;
                        end else if (i == 0 && ucode[i] != `CMD_RSVD && ucode[i] != `CMD_SETUP) begin
                           opc_q[i] <= ucode[i];
                           chunk_q[i] <= 32'h0;
                           st_q[i] <= S_SEND;
                           busy_q[i] <= 1'b1;
                        end else begin
                           err_q[i] <= err_q[i] | `ERR_INVALID;
                        end
                     end
                  end
                  S_WAIT: begin
                     chunk_q[i] <= nchunk[i];
                     if (rem_q[i] == 32'h0) begin
                        st_q[i] <= (opc_q[i] == `CMD_READ) ? S_DRAIN : S_IDLE;
                        busy_q[i] <= (opc_q[i] == `CMD_READ);
                     end else if (opc_q[i] == `CMD_WRITE) begin
                        if (fill_q[i] >= 17'(nchunk[i] << `UNIT_BEAT_SHIFT)) begin
                           st_q[i] <= S_SEND;
                        end
                     end else if (CAP - fill_q[i] >= 17'(nchunk[i] << `UNIT_BEAT_SHIFT)) begin
                        st_q[i] <= S_SEND;
                     end
                  end
                  S_SEND: begin
                     if (gnt[i]) begin
                        st_q[i] <= S_STAT;
                     end
                  end
                  S_STAT: begin
                     if (comp_chg && comp_port_l_q == 2'(i)) begin
                        if (opc_q[i] == `CMD_WRITE || opc_q[i] == `CMD_READ || opc_q[i] == `CMD_FLUSH) begin
                           io_completion_status_q[i] <= comp_status_l_q;
                        end else begin
                           admin_completion_status_q <= comp_status_l_q;
                        end
                        if (comp_status_l_q != `STATUS_OK) begin
                           err_q[i] <= err_q[i] | ((opc_q[i] == `CMD_SETUP) ? `ERR_SETUP : `ERR_DRIVE);
                           kill_q <= (opc_q[i] == `CMD_SETUP);
                           st_q[i] <= S_IDLE;
                           busy_q[i] <= 1'b0;
                        end else begin
                           unique case (opc_q[i])
                              `CMD_SETUP: begin
                                 init_done_q <= 1'b1;
                                 st_q[i] <= S_IDLE;
                              end
                              `CMD_IDENT: begin
                                 disk_capacity_blocks_q <= comp_param_l_q[47:0];
                                 block_unit_select_q <= comp_param_l_q[`UNIT_BIT];
                                 st_q[i] <= S_XFER;
                              end
                              `CMD_LOG: st_q[i] <= S_XFER;
                              `CMD_SHUT: kill_q <= 1'b1;
                              `CMD_WRITE, `CMD_READ: begin
                                 rem_q[i] <= rem_q[i] - chunk_q[i];
                                 addr_q[i] <= addr_q[i] + 48'(chunk_q[i]);
                                 st_q[i] <= S_WAIT;
                              end
                              default: begin
                                 st_q[i] <= S_IDLE;
                                 busy_q[i] <= 1'b0;
                              end
                           endcase
                        end
                     end
                  end
                  S_XFER: begin
                     if (xfer_cnt_q == ((opc_q[i] == `CMD_LOG) ? `LOG_LAST_WORD : `IDEN_LAST_WORD)) begin
                        st_q[i] <= S_IDLE;
                        busy_q[i] <= 1'b0;
                     end
                  end
                  S_DRAIN: begin
                     if (fill_q[i] == 17'h0) begin
                        st_q[i] <= S_IDLE;
                        busy_q[i] <= 1'b0;
                     end
                  end
                  S_DEAD: st_q[i] <= S_DEAD;
               endcase
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Data buffers (occupancy) and user flow control
   // ---------------------------------------------------------------
   // Writes drain a chunk when sent; reads add a chunk on any completion, good or bad.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         fill_d[i] = fill_q[i] + {16'h0, wr_valid[i] & wr_ready_q[i]}
                   - {16'h0, rd_valid_q[i] & rd_ready[i]};
         if (gnt[i] && opc_q[i] == `CMD_WRITE) begin
            fill_d[i] = fill_d[i] - 17'(chunk_q[i] << `UNIT_BEAT_SHIFT);
         end
         if (st_q[i] == S_STAT && comp_chg && comp_port_l_q == 2'(i) && opc_q[i] == `CMD_READ) begin
            fill_d[i] = fill_d[i] + 17'(chunk_q[i] << `UNIT_BEAT_SHIFT);
         end
      end
   end

   // Buffer count and registered ready/valid per port.
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (srst) begin
            fill_q[i] <= 17'h0;
            wr_ready_q[i] <= 1'b0;
            rd_valid_q[i] <= 1'b0;
         end else begin
            fill_q[i] <= fill_d[i];
            wr_ready_q[i] <= busy_q[i] && opc_q[i] == `CMD_WRITE && fill_d[i] < CAP;
            rd_valid_q[i] <= opc_q[i] == `CMD_READ && fill_d[i] != 17'h0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Identify and health-log word strobes, errors
   // ---------------------------------------------------------------
   // Words are indexed while port 0 sits in transfer.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         xfer_cnt_q <= 8'h0;
         custom_ram_wr_q <= 1'b0;
         custom_ram_word_index_q <= 5'h0;
         ident_ram_wr_q <= 1'b0;
         ident_ram_word_index_q <= 8'h0;
         error_code_q <= 4'h0;
         error_q <= 1'b0;
      end else begin
         xfer_cnt_q <= (st_q[0] == S_XFER) ? xfer_cnt_q + 8'h1 : 8'h0;
         custom_ram_wr_q <= st_q[0] == S_XFER && opc_q[0] == `CMD_LOG;
         custom_ram_word_index_q <= xfer_cnt_q[4:0];
         ident_ram_wr_q <= st_q[0] == S_XFER && opc_q[0] == `CMD_IDENT;
         ident_ram_word_index_q <= xfer_cnt_q;
         error_code_q <= err_q[0] | err_q[1] | err_q[2] | err_q[3];
         error_q <= |(err_q[0] | err_q[1] | err_q[2] | err_q[3]);
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   sequence s_pkt_open;
      tx_valid_q && !tx_last_q;
   endsequence
   property p_tx_hold;
      @(posedge link_clk) disable iff (lrst) s_pkt_open |=> tx_valid_q;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("valid dropped mid-packet");
   property p_tx_two;
      @(posedge link_clk) disable iff (lrst) s_pkt_open ##0 tx_ready |=> tx_valid_q && tx_last_q;
   endproperty
   a_tx_two: assert property (p_tx_two) else $error("packet not two beats");
   property p_sec_bad;
      @(posedge ref_clk) disable iff (srst) st_q[1] == S_IDLE && cmd_req[1] && !kill_q
         && secondary_port_command_code[0][2:1] != 2'h1 |=> st_q[1] == S_IDLE && err_q[1][2];
   endproperty
   a_sec_bad: assert property (p_sec_bad) else $error("bad code accepted");
   property p_cap;
      @(posedge ref_clk) disable iff (srst) fill_q[1] <= CAP;
   endproperty
   a_cap: assert property (p_cap) else $error("buffer overfilled");
   property p_init;
      @(posedge ref_clk) disable iff (srst) !init_done_q |-> !busy_q[2] && st_q[2] != S_SEND;
   endproperty
   a_init: assert property (p_init) else $error("port busy before init");
   property p_kill;
      @(posedge ref_clk) disable iff (srst) kill_q |=> st_q[3] == S_DEAD ##1 st_q[3] == S_DEAD;
   endproperty
   a_kill: assert property (p_kill) else $error("engine alive after shutdown");
   property p_wr_wait;
      @(posedge ref_clk) disable iff (srst) st_q[0] == S_WAIT && opc_q[0] == `CMD_WRITE
         && rem_q[0] != 32'h0 && fill_q[0] < 17'(nchunk[0] << `UNIT_BEAT_SHIFT) |=> st_q[0] != S_SEND;
   endproperty
   a_wr_wait: assert property (p_wr_wait) else $error("write sent short");
   property p_drain;
      @(posedge ref_clk) disable iff (srst) st_q[0] == S_DRAIN && fill_q[0] != 17'h0 && !kill_q
         |=> st_q[0] == S_DRAIN;
   endproperty
   a_drain: assert property (p_drain) else $error("read ended undrained");
   property p_idle;
      @(posedge ref_clk) disable iff (srst) $rose(st_q[2] == S_IDLE) && init_done_q |-> !busy_q[2];
   endproperty
   a_idle: assert property (p_idle) else $error("busy while idle");
   property p_log_idx;
      @(posedge ref_clk) disable iff (srst) custom_ram_wr_q |-> $past(st_q[0]) == S_XFER;
   endproperty
   a_log_idx: assert property (p_log_idx) else $error("log word outside transfer");
endmodule
`default_nettype wire

// ===== shared/nvme_host_map.svh
// Command codes, chunk sizes, buffer depths and error bits of the host.
`ifndef NVME_HOST_MAP_SVH
`define NVME_HOST_MAP_SVH
`define CMD_IDENT 3'h0
`define CMD_SHUT 3'h1
`define CMD_WRITE 3'h2
`define CMD_READ 3'h3
`define CMD_LOG 3'h4
`define CMD_FLUSH 3'h6
`define CMD_SETUP 3'h7
`define CMD_RSVD 3'h5
`define CHUNK_UNITS 32'h00000100
`define UNIT_BEAT_SHIFT 4
`define CAP_BEATS_BIG 17'h08000
`define CAP_BEATS_SMALL 17'h02000
`define LOG_LAST_WORD 8'h1f
`define IDEN_LAST_WORD 8'hff
`define STATUS_OK 16'h0000
`define ERR_SETUP 4'h1
`define ERR_DRIVE 4'h2
`define ERR_INVALID 4'h4
`define UNIT_BIT 48
`endif

// ===== shared/nvme_host_pkg.sv
// Types shared by the host command engines.
package nvme_host_pkg;
   // Engine states, one-hot.
   typedef enum logic [7:0] {
      S_INIT = 8'h01,
      S_IDLE = 8'h02,
      S_WAIT = 8'h04,
      S_SEND = 8'h08,
      S_STAT = 8'h10,
      S_XFER = 8'h20,
      S_DRAIN = 8'h40,
      S_DEAD = 8'h80
   } eng_state_t;
endpackage

// ===== testbench/drive_model.sv
// Behavioural drive that answers each command packet on the link clock.
`timescale 1ns/1ns
`default_nettype none
module drive_model (
   input wire logic link_clk,
   input wire logic [255:0] tx_data_q,
   input wire logic tx_valid_q,
   input wire logic tx_last_q,
   input wire logic bad,
   input wire logic [63:0] ident_param,
   output logic tx_ready,
   output logic rx_valid,
   output logic [1:0] rx_port,
   output logic [15:0] rx_status,
   output logic [63:0] rx_param,
   output int n_pkts
);
   logic [255:0] head = '0; // First beat of the packet in flight.
   logic mid = 1'b0; // High between the first and the last beat.
   int gap = 0; // Link cycles left before the completion goes back.
   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_port = '0;
      rx_status = '0;
      rx_param = '0;
      n_pkts = 0;
   end
   // -----------------------------------------------------------
   // Packet intake, random stalls and delayed completion.
   // -----------------------------------------------------------
   always @(posedge link_clk) begin
      rx_valid <= 1'b0;
      rx_port <= ~rx_port;
      rx_status <= ~rx_status;
      rx_param <= ~rx_param;
      // One command in flight: intake stalls until its completion has gone back.
      tx_ready <= (gap == 0) && ($urandom_range(3) != 0);
      if (tx_valid_q && tx_ready) begin
         if (!mid) head <= tx_data_q;
         mid <= !tx_last_q;
         if (tx_last_q) gap <= 12;
      end else if (gap > 1) begin
         gap <= gap - 1;
      end else if (gap == 1) begin
         gap <= 0;
         rx_valid <= 1'b1;
         rx_port <= head[89:88];
         rx_status <= bad ? 16'h0002 : 16'h0000;
         rx_param <= ident_param;
         n_pkts <= n_pkts + 1;
      end
   end
endmodule
`default_nettype wire

// ===== testbench/multi_user_nvme_host_cmd_tb_top.sv
// Self-checking bench driving all four user ports against the drive model.
`include "nvme_host_map.svh"
`timescale 1ns/1ns
`default_nettype none
module multi_user_nvme_host_cmd_tb_top;
   logic ref_clk = 1'b0, link_clk = 1'b0, srst = 1'b1, link_up = 1'b0, bad = 1'b0;
   logic [3:0] cmd_req = '0, wr_valid = '0, rd_ready = '0, bz = '0;
   logic [2:0] main_port_command_code = '0;
   logic [2:0][2:0] secondary_port_command_code = '0;
   logic [3:0][47:0] start_addr = '0;
   logic [3:0][31:0] xfer_len = '0;
   logic [511:0] custom_submission_dwords = '0;
   logic [63:0] ident_param = '0;
   logic [3:0] wr_ready_q, rd_valid_q, busy_q, error_code_q;
   logic [15:0] admin_completion_status_q, rx_status;
   logic [3:0][15:0] io_completion_status_q;
   logic [47:0] disk_capacity_blocks_q;
   logic block_unit_select_q, custom_ram_wr_q, ident_ram_wr_q, error_q;
   logic tx_valid_q, tx_last_q, tx_ready, rx_valid;
   logic [4:0] custom_ram_word_index_q;
   logic [7:0] ident_ram_word_index_q;
   logic [255:0] tx_data_q;
   logic [1:0] rx_port;
   logic [63:0] rx_param;
   logic [48:0] note;
   logic [48:0] exp_q [4][$]; // Per port: admin flag, beat count, status.
   int n_pkts, n_errors = 0, check_count = 0;
   int wr_left [4] = '{default: 0};
   int cnt [4] = '{default: 0};
   initial forever #20 ref_clk = ~ref_clk;
   initial begin
      #7;
      forever #24 link_clk = ~link_clk;
   end
   multi_user_nvme_host_cmd multi_user_nvme_host_cmd_i (.*);
   drive_model drive_model_i (.*);
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Issues one command; waits for completion only when go is set, then four more edges.
   task automatic cmd(input int p, input logic [2:0] code, input int len, input bit adm,
                      input logic [15:0] st, input int beats, input bit go);
      int n;
      @(posedge ref_clk);
      if (p == 0) main_port_command_code <= code;
      else secondary_port_command_code[p-1] <= code;
      start_addr[p] <= {16'($urandom), $urandom};
      xfer_len[p] <= len;
      cmd_req[p] <= 1'b1;
      if (go) exp_q[p].push_back({adm, beats[31:0], st});
      if (go && code == `CMD_WRITE) wr_left[p] = beats;
      @(posedge ref_clk);
      cmd_req[p] <= 1'b0;
      // Busy shows only from the edge after the one that takes the request.
      @(posedge ref_clk);
      n = 0;
      while (go && busy_q[p] !== 1'b0 && n < 40000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 40000) begin
         n_errors++;
         tally_and_finish();
      end
      repeat (4) @(posedge ref_clk);
   endtask
   // -----------------------------------------------------------
   // Stream drivers and the completion monitor.
   // -----------------------------------------------------------
   always @(posedge ref_clk) begin
      if (custom_ram_wr_q) chk(custom_ram_word_index_q, cnt[0], "log index");
      if (ident_ram_wr_q) chk(ident_ram_word_index_q, cnt[0], "ident index");
      if (custom_ram_wr_q || ident_ram_wr_q) cnt[0]++;
      for (int p = 0; p < 4; p++) begin
         if ((wr_valid[p] && wr_ready_q[p]) || (rd_valid_q[p] && rd_ready[p])) cnt[p]++;
         if (wr_valid[p] && wr_ready_q[p]) wr_left[p]--;
         if (!wr_valid[p] || wr_ready_q[p]) wr_valid[p] <= wr_left[p] > 0 && $urandom_range(3) > 0;
         rd_ready[p] <= 1'($urandom_range(1));
         if (bz[p] && !busy_q[p] && exp_q[p].size() > 0) begin
            note = exp_q[p].pop_front();
            chk({cnt[p], note[48] ? admin_completion_status_q : io_completion_status_q[p]},
                note[47:0], "completion");
            cnt[p] = 0;
         end
      end
      bz <= busy_q;
   end
   initial begin
      int l1, l2;
      void'($urandom(32'h0cc3));
      ident_param = {$urandom, $urandom};
      for (int i = 0; i < 16; i++) custom_submission_dwords[i*32 +: 32] = $urandom;
      // The drive answers to the port field of beat 0; custom commands belong to port 0.
      custom_submission_dwords[89:88] = 2'h0;
      l1 = $urandom_range(260, 257);
      l2 = $urandom_range(260, 257);
      repeat (5) @(posedge ref_clk);
      srst <= 1'b0;
      link_up <= 1'b1;
      for (int n = 0; n < 2000 && n_pkts == 0; n++) @(posedge ref_clk);
      repeat (20) @(posedge ref_clk);
      chk(n_pkts, 1, "setup");
      cmd(0, `CMD_IDENT, 0, 1, 16'h0, 256, 1);
      chk({block_unit_select_q, disk_capacity_blocks_q}, ident_param[48:0], "ident");
      fork
         cmd(1, `CMD_WRITE, l1, 0, 16'h0, l1 * 16, 1);
         cmd(2, `CMD_READ, l2, 0, 16'h0, l2 * 16, 1);
         cmd(3, `CMD_READ, 3, 0, 16'h0, 48, 1);
         cmd(0, `CMD_WRITE, 2, 0, 16'h0, 32, 1);
      join
      cmd(0, `CMD_LOG, 0, 1, 16'h0, 32, 1);
      bad <= 1'b1;
      cmd(0, `CMD_FLUSH, 0, 0, 16'h0002, 0, 1);
      bad <= 1'b0;
      chk({error_q, error_code_q}, 5'h12, "drive error");
      cmd(1, 3'h4, 1, 0, 16'h0, 0, 0);
      chk({error_code_q, busy_q}, 8'h60, "sub code");
      cmd(0, 3'h5, 1, 0, 16'h0, 0, 0);
      chk({error_code_q, busy_q}, 8'h60, "bad code");
      cmd(0, `CMD_SHUT, 0, 1, 16'h0, 0, 1);
      cmd(1, `CMD_WRITE, 1, 0, 16'h0, 16, 0);
      chk(busy_q, 4'h0, "after shutdown");
      tally_and_finish();
   end
endmodule
`default_nettype wire
